/* File: core/utrx_defines.vh */
`ifndef UTRX_DEFINES_VH
`define UTRX_DEFINES_VH
// register byte offsets
`define UTRX_OFS_STATUS 8'h00
`define UTRX_OFS_CTL1 8'h04
`define UTRX_OFS_CTL2 8'h08
`define UTRX_OFS_BAUD 8'h0c
`define UTRX_OFS_TXDATA 8'h10
`define UTRX_OFS_RXDATA 8'h14
// control one fields
`define UTRX_C1_EN 0
`define UTRX_C1_TX_ENABLE_CTL 1
`define UTRX_C1_RX_ENABLE_CTL 2
`define UTRX_C1_WL 3
`define UTRX_C1_PEN 4
`define UTRX_C1_PTYPE 5
`define UTRX_C1_STOP2 6
`define UTRX_C1_TX9 7
// control two fields
`define UTRX_C2_HS 0
`define UTRX_C2_TX_EMPTY_IRQ_EN 1
`define UTRX_C2_RIE 2
`define UTRX_C2_BRK 3
// timing
`define UTRX_TICK_LAST 4'hf
`define UTRX_SMP_A 4'h7
`define UTRX_SMP_B 4'h8
`define UTRX_SMP_C 4'h9
`define UTRX_BRK_LAST 4'hc
`define UTRX_LAST8 4'h7
`define UTRX_LAST9 4'h8
`define UTRX_FIFO_DEPTH 2
`define UTRX_FIFO_FULL 2'h2
`endif

/* File: core/utrx_core.v */
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "utrx_defines.vh"

module utrx_core (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // serial line
    input wire rx_in,
    output reg tx_out,
    output reg tx_oe,
    // interrupt requests
    output reg tx_irq,
    output reg rx_irq
);
    localparam TX_IDLE = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA = 3'h2;
    localparam TX_STOP = 3'h3;
    localparam TX_BRK = 3'h4;
    localparam RX_HUNT = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA = 3'h2;
    localparam RX_STOP = 3'h3;
    localparam RX_WAITHI = 3'h4;

    reg [7:0] uart_control_one_ff;
    reg [3:0] ctl2_ff;
    reg [7:0] baud_divisor_reg_ff;
    reg dph_wr_ff;
    reg [7:0] dph_addr_ff;
    reg arm_ff;
    reg [9:0] bdc_ff;
    reg [2:0] txs_ff;
    reg [3:0] txt_ff;
    reg [3:0] txi_ff;
    reg [8:0] tx_shift_reg_ff;
    reg [8:0] tx_data_reg_ff;
    reg tpend_ff;
    reg tbrk_ff;
    reg tx_idle_flag_ff;
    reg [2:0] rxs_ff;
    reg [3:0] rxt_ff;
    reg [3:0] rxi_ff;
    reg [8:0] rx_shift_reg_ff;
    reg [1:0] smp_ff;
    reg rnoise_ff;
    reg rferr_ff;
    reg [10:0] rx_data_fifo_ff [0:`UTRX_FIFO_DEPTH-1];
    reg [1:0] fcnt_ff;
    reg rx_available_flag_ff;
    reg noise_flag_ff;
    reg overrun_flag_ff;
    reg rx_idle_flag_ff;
    reg [31:0] rd_data;
    integer i;

    wire uart_enable_ctl = uart_control_one_ff[`UTRX_C1_EN];
    wire tx_enable_ctl = uart_control_one_ff[`UTRX_C1_TX_ENABLE_CTL];
    wire rx_enable_ctl = uart_control_one_ff[`UTRX_C1_RX_ENABLE_CTL];
    wire word_length_sel = uart_control_one_ff[`UTRX_C1_WL];
    wire parity_enable_ctl = uart_control_one_ff[`UTRX_C1_PEN];
    wire parity_type_sel = uart_control_one_ff[`UTRX_C1_PTYPE];
    wire stop_count_sel = uart_control_one_ff[`UTRX_C1_STOP2];
    wire baud_high_speed_sel = ctl2_ff[`UTRX_C2_HS];
    wire tx_empty_irq_en = ctl2_ff[`UTRX_C2_TX_EMPTY_IRQ_EN];
    wire rx_irq_en = ctl2_ff[`UTRX_C2_RIE];
    wire send_break_ctl = ctl2_ff[`UTRX_C2_BRK];

    // bus decode: reads act in the address phase, writes in the data phase
    wire acc = hsel & htrans[1] & hready;
    wire rd_acc = acc & ~hwrite;
    wire st_rd = rd_acc & (haddr[7:0] == `UTRX_OFS_STATUS);
    wire rx_rd = rd_acc & (haddr[7:0] == `UTRX_OFS_RXDATA);
    wire tx_wr = dph_wr_ff & (dph_addr_ff == `UTRX_OFS_TXDATA);
    wire c1_wr = dph_wr_ff & (dph_addr_ff == `UTRX_OFS_CTL1);
    wire c2_wr = dph_wr_ff & (dph_addr_ff == `UTRX_OFS_CTL2);
    wire bd_wr = dph_wr_ff & (dph_addr_ff == `UTRX_OFS_BAUD);

    // 16x tick: 4(n+1) clocks normal, n+1 clocks high speed
    wire [9:0] bd_lim = baud_high_speed_sel ? {2'h0, baud_divisor_reg_ff} :
                        {baud_divisor_reg_ff, 2'h3};
    wire tick = (bdc_ff == bd_lim);

    // transmit path
    wire tx_run = uart_enable_ctl & tx_enable_ctl;
    wire [3:0] nlast = word_length_sel ? `UTRX_LAST9 : `UTRX_LAST8;
    wire [8:0] tx_word = {uart_control_one_ff[`UTRX_C1_TX9], hwdata[7:0]};
    wire tx_bit_end = tick & (txt_ff == `UTRX_TICK_LAST);
    wire tx_idle_st = (txs_ff == TX_IDLE);
    wire tx_wr_go = tx_wr & tx_run & tx_idle_st & ~send_break_ctl & ~tpend_ff;
    wire tx_wr_buf = tx_wr & ~tpend_ff & ~tx_wr_go;
    wire tx_ld_buf = tx_run & tx_idle_st & ~send_break_ctl & tpend_ff;
    wire tx_brk_go = tx_run & tx_idle_st & send_break_ctl;
    wire [8:0] tx_low = tx_shift_reg_ff & (word_length_sel ? 9'h0ff : 9'h07f);
    wire tx_par = (^tx_low) ^ parity_type_sel;
    wire tx_bit = (parity_enable_ctl && txi_ff == nlast) ? tx_par : tx_shift_reg_ff[txi_ff];
    wire tx_frame_end = tx_bit_end & (txs_ff == TX_STOP) &
                        (~stop_count_sel | txi_ff[0]);
    wire tx_buffer_empty_flag = ~tpend_ff;

    // receive path
    wire rx_run = uart_enable_ctl & rx_enable_ctl;
    wire vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rx_in) | (smp_ff[1] & rx_in);
    wire noisy = (smp_ff[0] ^ smp_ff[1]) | (smp_ff[0] ^ rx_in);
    wire rx_frame = (rxs_ff == RX_START) | (rxs_ff == RX_DATA) | (rxs_ff == RX_STOP);
    wire rx_eval = tick & (rxt_ff == `UTRX_SMP_C) & rx_frame;
    wire rx_done = rx_eval & (rxs_ff == RX_STOP) & (~stop_count_sel | rxi_ff[0]);
    wire [8:0] rx_dw = word_length_sel ? rx_shift_reg_ff : {1'b0, rx_shift_reg_ff[7:0]};
    wire rx_parity_error_flag = parity_enable_ctl & ((^rx_dw) ^ parity_type_sel);
    wire rx_framing_error_flag = rferr_ff | ~vote;
    wire [10:0] rx_word = {rx_parity_error_flag, rx_framing_error_flag, rx_dw};
    wire pop = rx_rd & (fcnt_ff != 2'h0);
    wire push = rx_done & ((fcnt_ff != `UTRX_FIFO_FULL) | pop);
    wire ovf = rx_done & ~push;
    wire [1:0] widx = fcnt_ff - {1'b0, pop};
    wire rx_clr = rx_rd & arm_ff;
    wire [10:0] head = (fcnt_ff != 2'h0) ? rx_data_fifo_ff[0] : 11'h000;

    always @* begin
        rd_data = 32'h0000_0000;
        case (haddr[7:0])
            `UTRX_OFS_STATUS: rd_data = {24'h00_0000, tx_buffer_empty_flag, tx_idle_flag_ff,
                rx_available_flag_ff, rx_idle_flag_ff, overrun_flag_ff, head[9],
                noise_flag_ff, head[10]};
            `UTRX_OFS_CTL1: rd_data = {23'h00_0000, head[8], uart_control_one_ff};
            `UTRX_OFS_CTL2: rd_data = {28'h000_0000, ctl2_ff};
            `UTRX_OFS_BAUD: rd_data = {24'h00_0000, baud_divisor_reg_ff};
            `UTRX_OFS_RXDATA: rd_data = {24'h00_0000, head[7:0]};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // bus slave: zero wait state, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_ff <= 1'b0;
            dph_addr_ff <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dph_wr_ff <= acc & hwrite;
            dph_addr_ff <= haddr[7:0];
            hrdata <= rd_acc ? rd_data : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // control registers; disable drops the enables and the break request
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_control_one_ff <= 8'h00;
            ctl2_ff <= 4'h0;
            baud_divisor_reg_ff <= 8'h00;
        end else begin
            if (c1_wr) begin
                uart_control_one_ff <= hwdata[7:0] & {5'h1f, {2{hwdata[`UTRX_C1_EN]}}, 1'b1};
            end else if (!uart_enable_ctl) begin
                uart_control_one_ff[`UTRX_C1_TX_ENABLE_CTL] <= 1'b0;
                uart_control_one_ff[`UTRX_C1_RX_ENABLE_CTL] <= 1'b0;
            end
            if (c2_wr) begin
                ctl2_ff <= hwdata[3:0] & {uart_enable_ctl, 3'h7};
            end else if (!uart_enable_ctl) begin
                ctl2_ff[`UTRX_C2_BRK] <= 1'b0;
            end
            if (bd_wr) begin
                baud_divisor_reg_ff <= hwdata[7:0];
            end
        end
    end

    // status read arms the clearing sequence; a new status read wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_ff <= 1'b0;
        end else if (st_rd) begin
            arm_ff <= 1'b1;
        end else if (tx_wr | rx_rd) begin
            arm_ff <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bdc_ff <= 10'h000;
        end else if (!uart_enable_ctl || tick) begin
            bdc_ff <= 10'h000;
        end else begin
            bdc_ff <= bdc_ff + 10'h001;
        end
    end

    // transmit holding register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tpend_ff <= 1'b0;
            tx_data_reg_ff <= 9'h000;
        end else if (!uart_enable_ctl) begin
            tpend_ff <= 1'b0;
        end else if (tx_wr_buf) begin
            tpend_ff <= 1'b1;
            tx_data_reg_ff <= tx_word;
        end else if (tx_ld_buf) begin
            tpend_ff <= 1'b0;
        end
    end

    // transmit frame engine; dropping the enable stops it at once
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txs_ff <= TX_IDLE;
            txt_ff <= 4'h0;
            txi_ff <= 4'h0;
            tbrk_ff <= 1'b0;
            tx_shift_reg_ff <= 9'h000;
        end else if (!tx_run) begin
            txs_ff <= TX_IDLE;
            txt_ff <= 4'h0;
            txi_ff <= 4'h0;
            tbrk_ff <= 1'b0;
        end else begin
            if (tick) begin
                txt_ff <= txt_ff + 4'h1;
            end
            case (txs_ff)
                TX_IDLE: begin
                    txt_ff <= 4'h0;
                    txi_ff <= 4'h0;
                    if (tx_brk_go) begin
                        tbrk_ff <= 1'b1;
                        txs_ff <= TX_START;
                    end else if (tx_wr_go) begin
                        tbrk_ff <= 1'b0;
                        tx_shift_reg_ff <= tx_word;
                        txs_ff <= TX_START;
                    end else if (tx_ld_buf) begin
                        tbrk_ff <= 1'b0;
                        tx_shift_reg_ff <= tx_data_reg_ff;
                        txs_ff <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        txs_ff <= tbrk_ff ? TX_BRK : TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        txi_ff <= (txi_ff == nlast) ? 4'h0 : txi_ff + 4'h1;
                        txs_ff <= (txi_ff == nlast) ? TX_STOP : TX_DATA;
                    end
                end
                TX_BRK: begin
                    if (tx_bit_end) begin
                        if (txi_ff == `UTRX_BRK_LAST) begin
                            txi_ff <= 4'h0;
                            txs_ff <= send_break_ctl ? TX_BRK : TX_STOP;
                        end else begin
                            txi_ff <= txi_ff + 4'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_frame_end) begin
                        txs_ff <= TX_IDLE;
                        tbrk_ff <= 1'b0;
                    end else if (tx_bit_end) begin
                        txi_ff <= 4'h1;
                    end
                end
                default: txs_ff <= TX_IDLE;
            endcase
        end
    end

    // line drive and transmit flags
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_out <= 1'b1;
            tx_oe <= 1'b0;
            tx_idle_flag_ff <= 1'b1;
            tx_irq <= 1'b0;
        end else begin
            tx_oe <= tx_run;
            case (txs_ff)
                TX_START: tx_out <= 1'b0;
                TX_DATA: tx_out <= tx_bit;
                TX_BRK: tx_out <= 1'b0;
                default: tx_out <= 1'b1;
            endcase
            if (!uart_enable_ctl || tx_frame_end) begin
                tx_idle_flag_ff <= 1'b1;
            end else if (tx_wr & ~tpend_ff) begin
                tx_idle_flag_ff <= 1'b0;
            end
            // break frames leave the buffer empty, so mask them out
            tx_irq <= tx_empty_irq_en & tx_buffer_empty_flag & ~tbrk_ff;
        end
    end

    // receive engine; counter realigns on each start edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxs_ff <= RX_HUNT;
            rxt_ff <= 4'h0;
            rxi_ff <= 4'h0;
            rx_shift_reg_ff <= 9'h000;
            smp_ff <= 2'h3;
            rnoise_ff <= 1'b0;
            rferr_ff <= 1'b0;
        end else if (!rx_run) begin
            rxs_ff <= RX_HUNT;
            rxt_ff <= 4'h0;
        end else begin
            if (tick) begin
                rxt_ff <= rxt_ff + 4'h1;
                if (rxt_ff == `UTRX_SMP_A) begin
                    smp_ff[0] <= rx_in;
                end
                if (rxt_ff == `UTRX_SMP_B) begin
                    smp_ff[1] <= rx_in;
                end
            end
            if (rx_eval) begin
                rnoise_ff <= rnoise_ff | noisy;
            end
            case (rxs_ff)
                RX_HUNT: begin
                    rxt_ff <= 4'h0;
                    rxi_ff <= 4'h0;
                    if (!rx_in) begin
                        rxs_ff <= RX_START;
                        rx_shift_reg_ff <= 9'h000;
                        rnoise_ff <= 1'b0;
                        rferr_ff <= 1'b0;
                    end
                end
                RX_START: begin
                    if (rx_eval) begin
                        rxs_ff <= vote ? RX_HUNT : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_eval) begin
                        rx_shift_reg_ff[rxi_ff] <= vote;
                        rxi_ff <= (rxi_ff == nlast) ? 4'h0 : rxi_ff + 4'h1;
                        rxs_ff <= (rxi_ff == nlast) ? RX_STOP : RX_DATA;
                    end
                end
                RX_STOP: begin
                    if (rx_done) begin
                        rxs_ff <= rx_framing_error_flag ? RX_WAITHI : RX_HUNT;
                    end else if (rx_eval) begin
                        rferr_ff <= ~vote;
                        rxi_ff <= 4'h1;
                    end
                end
                RX_WAITHI: begin
                    if (rx_in) begin
                        rxs_ff <= RX_HUNT;
                    end
                end
                default: rxs_ff <= RX_HUNT;
            endcase
        end
    end

    // receive fifo, head at entry 0
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt_ff <= 2'h0;
            for (i = 0; i < `UTRX_FIFO_DEPTH; i = i + 1) begin
                rx_data_fifo_ff[i] <= 11'h000;
            end
        end else if (!uart_enable_ctl) begin
            fcnt_ff <= 2'h0;
        end else begin
            fcnt_ff <= fcnt_ff + {1'b0, push} - {1'b0, pop};
            for (i = 0; i < `UTRX_FIFO_DEPTH; i = i + 1) begin
                if (push && widx == i) begin
                    rx_data_fifo_ff[i] <= rx_word;
                end else if (pop && i < `UTRX_FIFO_DEPTH - 1) begin
                    rx_data_fifo_ff[i] <= rx_data_fifo_ff[(i + 1) % `UTRX_FIFO_DEPTH];
                end
            end
        end
    end

    // receive flags; a new event beats a same-cycle clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_available_flag_ff <= 1'b0;
            noise_flag_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            rx_idle_flag_ff <= 1'b1;
            rx_irq <= 1'b0;
        end else if (!uart_enable_ctl) begin
            rx_available_flag_ff <= 1'b0;
            noise_flag_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            rx_idle_flag_ff <= 1'b1;
            rx_irq <= 1'b0;
        end else begin
            if (push) begin
                rx_available_flag_ff <= 1'b1;
            end else if (rx_clr && fcnt_ff == 2'h1) begin
                rx_available_flag_ff <= 1'b0;
            end
            if (push && (rnoise_ff | noisy)) begin
                noise_flag_ff <= 1'b1;
            end else if (rx_clr) begin
                noise_flag_ff <= 1'b0;
            end
            if (ovf) begin
                overrun_flag_ff <= 1'b1;
            end else if (rx_clr) begin
                overrun_flag_ff <= 1'b0;
            end
            // a false start drops back to hunting, so idle returns with it
            if (!rx_run || rx_done || (rx_eval && rxs_ff == RX_START && vote)) begin
                rx_idle_flag_ff <= 1'b1;
            end else if (rxs_ff == RX_HUNT && !rx_in) begin
                rx_idle_flag_ff <= 1'b0;
            end
            // noise has no source of its own here
            rx_irq <= rx_irq_en & (rx_available_flag_ff | overrun_flag_ff);
        end
    end
endmodule // utrx_core

/* File: tb/utrx_core_sva.sv */
module utrx_core_sva (
    // bus side
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // serial and requests
    input wire rx_in,
    input wire tx_out,
    input wire tx_oe,
    input wire tx_irq,
    input wire rx_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic dp_ff, dw_ff, tx_empty_irq_en_ff, rie_ff, brk_ff, dis_ff, idl_ff;
    logic [7:0] da_ff;
    logic [11:0] low_ff;
    logic [9:0] rxh_ff;
    wire sr = dp_ff & ~dw_ff & (da_ff == 8'h00);
    wire txw = dp_ff & dw_ff & (da_ff == 8'h10);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // run limits assume divisor 0 with high speed, as the bench sets
    sequence start_s;
        ##[1:3] !tx_out;
    endsequence
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_ff <= 1'b0;
            dw_ff <= 1'b0;
            da_ff <= 8'h00;
            {tx_empty_irq_en_ff, rie_ff, brk_ff, idl_ff} <= 4'h0;
            dis_ff <= 1'b1;
            low_ff <= 12'h000;
            rxh_ff <= 10'h000;
        end else begin
            dp_ff <= hsel & htrans[1] & hready;
            if (hsel & htrans[1] & hready) begin
                da_ff <= haddr[7:0];
                dw_ff <= hwrite;
            end
            if (dp_ff & dw_ff & (da_ff == 8'h08))
                {brk_ff, rie_ff, tx_empty_irq_en_ff} <= hwdata[3:1];
            if (dp_ff & dw_ff & (da_ff == 8'h04))
                dis_ff <= ~hwdata[0];
            if (sr)
                idl_ff <= hrdata[6];
            if (txw) begin
                idl_ff <= 1'b0;
                dis_ff <= 1'b0;
            end
            low_ff <= (tx_oe & ~tx_out) ? low_ff + 12'h001 : 12'h000;
            rxh_ff <= !rx_in ? 10'h000 : (&rxh_ff) ? rxh_ff : rxh_ff + 10'h001;
        end
    end
    tx_irq_on_a: assert property (sr && hrdata[7] && tx_empty_irq_en_ff && !brk_ff |-> ##[0:2] tx_irq)
        else $error("tx request missing");
    tx_irq_off_a: assert property (!tx_empty_irq_en_ff && !$past(tx_empty_irq_en_ff) && !$past(tx_empty_irq_en_ff, 2) |-> !tx_irq)
        else $error("tx request while masked");
    brk_irq_a: assert property (low_ff > 12'h0aa |-> !tx_irq)
        else $error("tx request during break");
    low_run_a: assert property ($rose(tx_out) && tx_oe |-> low_ff[3:0] == 4'h0 &&
        (low_ff <= 12'h0a0 || (low_ff - 12'h010) % 12'h0d0 == 12'h000))
        else $error("bad low run on tx");
    rx_irq_on_a: assert property (sr && (hrdata[5] || hrdata[3]) && rie_ff |-> ##[0:2] rx_irq)
        else $error("rx request missing");
    rx_irq_off_a: assert property (!rie_ff && !$past(rie_ff) && !$past(rie_ff, 2) |-> !rx_irq)
        else $error("rx request while masked");
    idle_start_a: assert property (txw && idl_ff && tx_oe |-> start_s)
        else $error("idle write did not start");
    rx_idle_a: assert property (sr && rxh_ff >= 10'h190 |-> hrdata[4])
        else $error("rx not idle on quiet line");
    dis_stat_a: assert property (sr && dis_ff && $past(dis_ff) |-> hrdata[7:0] == 8'hd0)
        else $error("status wrong while disabled");
endmodule // utrx_core_sva

bind utrx_core utrx_core_sva chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));

/* File: tb/utrx_remote.sv */
module utrx_remote (
    // clock
    input wire hclk,
    // serial lines
    input wire tx_out,
    input wire tx_oe,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = 16; // clocks per bit at divisor 0, high speed
    logic [8:0] got;
    int n_got = 0;
    initial rx_line = 1'b1;
    task automatic drive(input logic b, input int n);
        rx_line <= b;
        repeat (n * BIT) @(posedge hclk);
    endtask
    task automatic send(input logic [8:0] w, input int nb);
        drive(1'b0, 1);
        for (int i = 0; i < nb; i++)
            drive(w[i], 1);
        drive(1'b1, 1);
    endtask
    // mid-bit sampling; got[8] holds the stop level
    initial begin
        forever begin
            @(negedge tx_out iff tx_oe);
            repeat (8) @(posedge hclk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge hclk);
                got[i] = tx_out;
            end
            n_got++;
            wait (tx_out === 1'b1);
        end
    end
endmodule // utrx_remote

/* File: tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, d;
    logic [1:0] htrans;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    time t0;
    wire hreadyout, hresp, rx_in, tx_out, tx_oe, tx_irq, rx_irq;
    wire [31:0] hrdata;
    utrx_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
    utrx_remote rem (.hclk(hclk), .tx_out(tx_out), .tx_oe(tx_oe), .rx_line(rx_in));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize();
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // wait states handled: both phases wait on hreadyout
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_n(input int k);
        int n = 0;
        while (rem.n_got < k && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        if (rem.n_got < k)
            mismatches++;
    endtask
    task automatic wait_tx(input logic b);
        int n = 0;
        while (tx_out !== b && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        if (tx_out !== b)
            mismatches++;
    endtask
    task automatic t_reset();
        rd(8'h00);
        chk(d, 32'h0000_00d0);
        rd(8'h20);
        chk(d, 32'h0000_0000);
        chk({hreadyout, hresp}, 2'h2);
        wr(8'h08, 32'h0000_0001);
        wr(8'h0c, 32'h0000_0000);
        wr(8'h04, 32'h0000_0007);
    endtask
    task automatic t_tx();
        rd(8'h00);
        wr(8'h10, 32'h0000_005a);
        rd(8'h00);
        chk(d[7:6], 2'h2);
        wr(8'h10, 32'h0000_00c3);
        rd(8'h00);
        chk(d[7], 1'b0);
        wait_n(1);
        chk(rem.got, 9'h15a);
        wait_n(2);
        chk(rem.got, 9'h1c3);
        repeat (20) @(posedge hclk);
        rd(8'h00);
        chk(d[7:6], 2'h3);
        wr(8'h08, 32'h0000_0003);
        rd(8'h00);
        chk(tx_irq, 1'b1);
        wr(8'h08, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        chk(tx_irq, 1'b0);
    endtask
    task automatic t_rx();
        wr(8'h08, 32'h0000_0005);
        rem.send(9'h035, 8);
        rem.send(9'h096, 8);
        rem.send(9'h00f, 8);
        repeat (4) @(posedge hclk);
        rd(8'h00);
        chk(d[5], 1'b1);
        chk(d[3], 1'b1);
        chk(rx_irq, 1'b1);
        rd(8'h14);
        chk(d, 32'h0000_0035);
        rd(8'h00);
        chk(d[3], 1'b0);
        rd(8'h14);
        chk(d, 32'h0000_0096);
        rd(8'h00);
        chk(d[5], 1'b0);
        chk(rx_irq, 1'b0);
    endtask
    task automatic t_rxbrk();
        rem.drive(1'b0, 14);
        rd(8'h00);
        chk(d[5], 1'b1);
        chk(d[2], 1'b1);
        rem.drive(1'b0, 12);
        rem.drive(1'b1, 2);
        rd(8'h14);
        chk(d, 32'h0000_0000);
        rd(8'h00);
        chk(d[5], 1'b0);
    endtask
    // break held past one character, then released mid-way
    task automatic t_send_break_ctl();
        wr(8'h08, 32'h0000_000b);
        wait_tx(1'b0);
        t0 = $time;
        repeat (100) @(posedge hclk);
        chk(tx_irq, 1'b0);
        repeat (200) @(posedge hclk);
        wr(8'h08, 32'h0000_0003);
        wait_tx(1'b1);
        chk(32'(($time - t0) / 100), 32'h0000_01b0);
        repeat (40) @(posedge hclk);
        rd(8'h00);
        chk(d[6], 1'b1);
    endtask
    task automatic t_dis();
        wr(8'h04, 32'h0000_004f);
        rem.send(9'h1a5, 9);
        rem.drive(1'b1, 1);
        rem.send(9'h03c, 9);
        rem.drive(1'b1, 1);
        repeat (4) @(posedge hclk);
        rd(8'h04);
        chk(d[8], 1'b1);
        rd(8'h00);
        chk(d[5:0], 6'h30);
        rd(8'h14);
        chk(d[7:0], 8'ha5);
        wr(8'h04, 32'h0000_0006);
        wr(8'h08, 32'h0000_0009);
        rd(8'h00);
        chk(d, 32'h0000_00d0);
        rd(8'h04);
        chk(d[2:0], 3'h0);
        rd(8'h08);
        chk(d, 32'h0000_0001);
        chk(tx_oe, 1'b0);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_tx();
        t_rx();
        t_rxbrk();
        t_send_break_ctl();
        t_dis();
        summarize();
    end
endmodule // tb
